// ==== hw/lrc_pkg.sv ====
// shared constants for the regulator control register bank
package lrc_pkg;

   // channel count and data widths
   localparam int LRC_NCH = 4;
   localparam int LRC_ADDR_W = 8;
   localparam int LRC_DATA_W = 8;
   localparam int LRC_VCODE_W = 6;

   // register offsets, channel a to d
   localparam logic [7:0] LRC_VOLT_OFS [LRC_NCH] = '{
      8'h50, 8'h58, 8'h60, 8'h68
   };
   localparam logic [7:0] LRC_CTRL_OFS [LRC_NCH] = '{
      8'h51, 8'h59, 8'h61, 8'h69
   };

   // control register field positions
   localparam int LRC_ON_BIT = 7;
   localparam int LRC_DIS_BIT = 2;
   localparam int LRC_FLT_BIT = 1;
   localparam int LRC_PG_BIT = 0;

   // voltage register field: code in the low bits
   localparam int LRC_VCODE_LSB = 0;

   // reset values
   localparam logic [5:0] LRC_VCODE_RST = 6'h00;
   localparam logic LRC_ON_RST = 1'b0;
   localparam logic LRC_DIS_RST = 1'b0;
   localparam logic LRC_FLT_RST = 1'b0;

   // read values of reserved bits and unmapped addresses
   localparam logic [1:0] LRC_VOLT_RSVD = 2'h0;
   localparam logic [3:0] LRC_CTRL_RSVD = 4'h0;
   localparam logic [7:0] LRC_UNMAPPED_RDATA = 8'h00;
   localparam logic [7:0] LRC_IDLE_RDATA = 8'h00;

endpackage

// ==== hw/lrc_channel.sv ====
// one regulator channel: voltage code, control bits and analog drives
`timescale 1ns/1ps
module lrc_channel
   import lrc_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic volt_wr, // write to this channel's voltage register
   input wire logic ctrl_wr, // write to this channel's control register
   input wire logic [lrc_pkg::LRC_DATA_W-1:0] wdata, // write data
   input wire logic fault_in, // fault indication from the regulator
   output logic [5:0] vcode_r, // output_voltage_code
   output logic on_r, // regulator enable
   output logic dis_r, // shutdown_discharge_enable
   output logic flt_en_r, // fault_irq_enable
   output logic discharge_r, // discharge switch drive
   output logic fault_irq_r // gated fault interrupt request
);
   logic [5:0] vcode_nxt;
   logic on_nxt;
   logic dis_nxt;
   logic flt_en_nxt;
   logic discharge_nxt;
   logic fault_irq_nxt;

   always_comb begin
      vcode_nxt = vcode_r;
      on_nxt = on_r;
      dis_nxt = dis_r;
      flt_en_nxt = flt_en_r;
      if (volt_wr) begin
         // bits 7:6 are not stored, so writes there vanish
         vcode_nxt = wdata[LRC_VCODE_LSB +: LRC_VCODE_W];
      end
      if (ctrl_wr) begin
         on_nxt = wdata[LRC_ON_BIT];
         dis_nxt = wdata[LRC_DIS_BIT];
         flt_en_nxt = wdata[LRC_FLT_BIT];
      end
      // computed from the next values so the switch follows the write
      // in the same edge and never overlaps a freshly enabled output
      discharge_nxt = dis_nxt & ~on_nxt;
      fault_irq_nxt = fault_in & flt_en_nxt;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         vcode_r <= LRC_VCODE_RST;
         on_r <= LRC_ON_RST;
         dis_r <= LRC_DIS_RST;
         flt_en_r <= LRC_FLT_RST;
         discharge_r <= 1'b0;
         fault_irq_r <= 1'b0;
      end else begin
         vcode_r <= vcode_nxt;
         on_r <= on_nxt;
         dis_r <= dis_nxt;
         flt_en_r <= flt_en_nxt;
         discharge_r <= discharge_nxt;
         fault_irq_r <= fault_irq_nxt;
      end
   end

endmodule

// ==== hw/lrc_ldo_regs.sv ====
// register bank for the low-dropout regulator channels
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps

module lrc_ldo_regs
   import lrc_pkg::*;
#(
   parameter int NCH = LRC_NCH
)
(
   input wire logic clock, // system clock, 10 MHz
   input wire logic rstn, // async reset, active low
   input wire logic [lrc_pkg::LRC_ADDR_W-1:0] addr, // register byte address
   input wire logic [lrc_pkg::LRC_DATA_W-1:0] wdata, // write data
   input wire logic wr_stb, // one-cycle write strobe
   input wire logic rd_stb, // one-cycle read strobe
   output logic [lrc_pkg::LRC_DATA_W-1:0] rdata, // read data after rd_stb
   input wire logic [NCH-1:0] power_good, // regulator above threshold
   input wire logic [NCH-1:0] fault, // regulator fault level
   output logic [NCH-1:0][5:0] output_voltage_code, // voltage setting
   output logic [NCH-1:0] regulator_enable, // regulator on
   output logic [NCH-1:0] discharge_switch, // discharge resistor on
   output logic [NCH-1:0] fault_irq_req // masked fault request
);

   // reserved spans follow from the field layout around them
   localparam int VRSVD_LSB = LRC_VCODE_LSB + LRC_VCODE_W;
   localparam int VRSVD_W = $bits(LRC_VOLT_RSVD);
   localparam int CRSVD_LSB = LRC_DIS_BIT + 1;
   localparam int CRSVD_W = $bits(LRC_CTRL_RSVD);
   localparam int FLD_MAX = LRC_DATA_W - 1;

   // the offset table only covers four channels
   if (NCH < 1 || NCH > LRC_NCH) begin : g_nch_check
      $error("lrc_ldo_regs: NCH must be 1 to 4");
   end

   // ports and read views are laid out for byte-wide registers
   if (LRC_ADDR_W != 8 || LRC_DATA_W != 8) begin : g_width_check
      $error("lrc_ldo_regs: address and data must be 8 bits");
   end

   // the code ports are as wide as the stored code
   if (LRC_VCODE_W != $bits(LRC_VCODE_RST)) begin : g_vcode_check
      $error("lrc_ldo_regs: voltage code width mismatch");
   end

   // code and reserved bits together must fill the voltage byte
   if (VRSVD_LSB + VRSVD_W != LRC_DATA_W) begin : g_volt_layout
      $error("lrc_ldo_regs: voltage register layout does not fill a byte");
   end

   // the reserved control span must sit between discharge and enable
   if (CRSVD_LSB + CRSVD_W != LRC_ON_BIT) begin : g_ctrl_layout
      $error("lrc_ldo_regs: control reserved span is misplaced");
   end

   // every control field needs a bit inside the byte
   if (LRC_ON_BIT > FLD_MAX || LRC_DIS_BIT > FLD_MAX ||
       LRC_FLT_BIT > FLD_MAX || LRC_PG_BIT > FLD_MAX) begin : g_fld_range
      $error("lrc_ldo_regs: control field outside the byte");
   end

   // fault enable and status must stay below the reserved span
   if (LRC_FLT_BIT >= CRSVD_LSB || LRC_PG_BIT >= CRSVD_LSB) begin : g_fld_low
      $error("lrc_ldo_regs: control field inside the reserved span");
   end

   // two fields on one bit would let one write clobber the other
   if (LRC_ON_BIT == LRC_DIS_BIT || LRC_ON_BIT == LRC_FLT_BIT ||
       LRC_ON_BIT == LRC_PG_BIT || LRC_DIS_BIT == LRC_FLT_BIT ||
       LRC_DIS_BIT == LRC_PG_BIT || LRC_FLT_BIT == LRC_PG_BIT) begin : g_uniq
      $error("lrc_ldo_regs: control fields share a bit");
   end

   // two registers on one address would make writes hit both and
   // break the one-hot read select below
   for (genvar ga = 0; ga < LRC_NCH; ga++) begin : g_ofs_a
      for (genvar gb = 0; gb < LRC_NCH; gb++) begin : g_ofs_b
         if (LRC_VOLT_OFS[ga] == LRC_CTRL_OFS[gb]) begin : g_mix
            $error("lrc_ldo_regs: voltage and control offsets overlap");
         end
         if (ga < gb && LRC_VOLT_OFS[ga] == LRC_VOLT_OFS[gb]) begin : g_vdup
            $error("lrc_ldo_regs: two voltage registers share an offset");
         end
         if (ga < gb && LRC_CTRL_OFS[ga] == LRC_CTRL_OFS[gb]) begin : g_cdup
            $error("lrc_ldo_regs: two control registers share an offset");
         end
      end
   end

   logic [NCH-1:0] volt_hit;
   logic [NCH-1:0] ctrl_hit;
   logic [NCH-1:0] volt_wr;
   logic [NCH-1:0] ctrl_wr;
   logic [NCH-1:0][5:0] vcode;
   logic [NCH-1:0] on;
   logic [NCH-1:0] dis;
   logic [NCH-1:0] flt_en;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [NCH-1:0][7:0] volt_view;
   logic [NCH-1:0][7:0] ctrl_view;
   logic any_hit;
   logic [7:0] rd_sel;

   // address decode: one hit per register
   always_comb begin
      any_hit = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         volt_hit[i] = (addr == LRC_VOLT_OFS[i]);
         ctrl_hit[i] = (addr == LRC_CTRL_OFS[i]);
         volt_wr[i] = wr_stb & volt_hit[i];
         ctrl_wr[i] = wr_stb & ctrl_hit[i];
         any_hit = any_hit | volt_hit[i] | ctrl_hit[i];
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      lrc_channel u_ch (
         .clock(clock),
         .rstn(rstn),
         .volt_wr(volt_wr[g]),
         .ctrl_wr(ctrl_wr[g]),
         .wdata(wdata),
         .fault_in(fault[g]),
         .vcode_r(vcode[g]),
         .on_r(on[g]),
         .dis_r(dis[g]),
         .flt_en_r(flt_en[g]),
         .discharge_r(discharge_switch[g]),
         .fault_irq_r(fault_irq_req[g])
      );
   end

   // software view of each register: fields go to their package bit
   // positions and the reserved spans read their fixed value
   always_comb begin
      volt_view = '0;
      ctrl_view = '0;
      for (int i = 0; i < NCH; i++) begin
         volt_view[i][LRC_VCODE_LSB +: LRC_VCODE_W] = vcode[i];
         volt_view[i][VRSVD_LSB +: VRSVD_W] = LRC_VOLT_RSVD;
         ctrl_view[i][LRC_ON_BIT] = on[i];
         ctrl_view[i][CRSVD_LSB +: CRSVD_W] = LRC_CTRL_RSVD;
         ctrl_view[i][LRC_DIS_BIT] = dis[i];
         ctrl_view[i][LRC_FLT_BIT] = flt_en[i];
         // status comes from the pin, so no stored copy can go stale
         ctrl_view[i][LRC_PG_BIT] = power_good[i];
      end
   end

   // the decode is one-hot, so an and-or select replaces a priority
   // chain; read data stands only in the cycle after the strobe, and an
   // unmapped address answers a fixed value rather than stale data
   always_comb begin
      rd_sel = '0;
      for (int i = 0; i < NCH; i++) begin
         rd_sel = rd_sel | ({8{volt_hit[i]}} & volt_view[i]);
         rd_sel = rd_sel | ({8{ctrl_hit[i]}} & ctrl_view[i]);
      end
      rdata_nxt = LRC_IDLE_RDATA;
      if (rd_stb) begin
         rdata_nxt = any_hit ? rd_sel : LRC_UNMAPPED_RDATA;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= LRC_IDLE_RDATA;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;
   assign output_voltage_code = vcode;
   assign regulator_enable = on;

endmodule

// ==== verification/lrc_ldo_regs_asserts.sv ====
// port assertions for the regulator register bank
`timescale 1ns/1ps
module lrc_ldo_regs_asserts
   import lrc_pkg::*;
#(parameter int NCH = LRC_NCH)
(
   input wire logic clock, // clock
   input wire logic rstn, // reset
   input wire logic [7:0] addr, // address
   input wire logic [7:0] wdata, // write data
   input wire logic wr_stb, // write
   input wire logic rd_stb, // read
   input wire logic [7:0] rdata, // read data
   input wire logic [NCH-1:0] power_good, // pg
   input wire logic [NCH-1:0] fault, // fault
   input wire logic [NCH-1:0][5:0] output_voltage_code, // code
   input wire logic [NCH-1:0] regulator_enable, // on
   input wire logic [NCH-1:0] discharge_switch, // discharge
   input wire logic [NCH-1:0] fault_irq_req // irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_code;
      wr_stb && addr == 8'h50 |=> output_voltage_code[0] == $past(wdata[5:0]);
   endproperty
   a_code: assert property (p_code) else $error("code");
   property p_on;
      wr_stb && addr == 8'h59 |=> regulator_enable[1] == $past(wdata[7]);
   endproperty
   a_on: assert property (p_on) else $error("enable");
   property p_dis;
      wr_stb && addr == 8'h59 |=>
         discharge_switch[1] == ($past(wdata[2]) && !$past(wdata[7]));
   endproperty
   a_dis: assert property (p_dis) else $error("discharge");
   property p_irq;
      fault_irq_req[2] |-> $past(fault[2]);
   endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_irq_off;
      wr_stb && addr == 8'h61 && !wdata[1] |=> !fault_irq_req[2];
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq off");
   property p_pg;
      rd_stb && addr == 8'h59 |=> rdata[0] == $past(power_good[1]);
   endproperty
   a_pg: assert property (p_pg) else $error("pg");
   property p_gnd;
      (discharge_switch & regulator_enable) == '0;
   endproperty
   a_gnd: assert property (p_gnd) else $error("ground");
   property p_rsv;
      rd_stb && addr == 8'h58 |=> rdata[7:6] == 2'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved");
   property p_rsv_ctl;
      rd_stb && addr == 8'h59 |=> rdata[6:3] == 4'h0;
   endproperty
   a_rsv_ctl: assert property (p_rsv_ctl) else $error("ctl rsvd");
endmodule

// ==== verification/lrc_ldo_regs_bench.sv ====
// self-checking bench for the regulator register bank
`timescale 1ns/1ps
module lrc_ldo_regs_bench;
   import lrc_pkg::*;
   logic clock = 1'b0, rstn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [3:0] power_good = 4'h0, fault = 4'h0;
   logic [3:0] regulator_enable, discharge_switch, fault_irq_req;
   logic [3:0][5:0] output_voltage_code;
   int n_errors = 0, n_checks = 0, cyc = 0;
   always #50 clock = ~clock;
   lrc_ldo_regs u_dut (.*);
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc > 2000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   // the trailing 1 ns lets the registered outputs settle before sampling
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clock);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         rd(LRC_VOLT_OFS[i], 8'h00);
         rd(LRC_CTRL_OFS[i], 8'h00);
      end
      rd(8'h52, 8'h00);
      $display("reset values done");
   endtask
   task automatic t_volt();
      for (int i = 0; i < 4; i++) begin
         wr(LRC_VOLT_OFS[i], 8'hf0 + 8'(i));
         chk("code", 8'h30 + 8'(i), {2'h0, output_voltage_code[i]});
         rd(LRC_VOLT_OFS[i], 8'h30 + 8'(i));
      end
      $display("voltage codes done");
   endtask
   task automatic t_ctrl();
      @(posedge clock) power_good <= 4'h2;
      wr(8'h59, 8'hfe);
      chk("on", 8'h01, {7'h0, regulator_enable[1]});
      chk("dis", 8'h00, {7'h0, discharge_switch[1]});
      rd(8'h59, 8'h87);
      wr(8'h59, 8'h7d);
      chk("off", 8'h00, {7'h0, regulator_enable[1]});
      chk("gnd", 8'h01, {7'h0, discharge_switch[1]});
      @(posedge clock) power_good <= 4'h0;
      rd(8'h59, 8'h04);
      $display("control bits done");
   endtask
   task automatic t_fault();
      @(posedge clock) fault <= 4'h4;
      wr(8'h61, 8'h00);
      @(posedge clock);
      #1 chk("masked", 8'h00, {7'h0, fault_irq_req[2]});
      wr(8'h61, 8'h02);
      @(posedge clock);
      #1 chk("irq", 8'h01, {7'h0, fault_irq_req[2]});
      $display("fault gating done");
   endtask
   // reset in mid-run with the fault still raised and discharge active
   task automatic t_rerst();
      @(posedge clock) rstn <= 1'b0;
      @(posedge clock) rstn <= 1'b1;
      #1 chk("rst on", 8'h00, {4'h0, regulator_enable});
      chk("rst gnd", 8'h00, {4'h0, discharge_switch});
      chk("rst irq", 8'h00, {4'h0, fault_irq_req});
      chk("rst code", 8'h00, {2'h0, output_voltage_code[1]});
      rd(8'h61, 8'h00);
      $display("mid-run reset done");
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      t_reset();
      t_volt();
      t_ctrl();
      t_fault();
      t_rerst();
      stop_test();
   end
endmodule
bind lrc_ldo_regs lrc_ldo_regs_asserts #(.NCH(NCH)) u_chk (.*);
